// *** dv/sfrs_spi_ctrl.sv ***
`timescale 1ns/1ps
module sfrs_spi_ctrl (
  // Serial link toward the block
  output logic sclk,
  output logic csb_n,
  output logic sdi
);
  // The link clock stands still and the select is high between frames.
  initial begin
    sclk = 1'b0;
    // A deferred update gives the bit counter a clearing edge at start.
    csb_n <= 1'b1;
    sdi = 1'b0;
  end

  // ************************************************************
  // Frame drivers
  // ************************************************************
  // Sends the top n bits of w. An n below 24 gives a truncated frame on purpose.
  task automatic send_bits(input logic [23:0] w, input int n);
    csb_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      sdi = w[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #15 csb_n = 1'b1;
    sdi = ~sdi; // A released line must not keep showing the last bit.
    #120;
  endtask : send_bits

  // One register write as a single 24-bit frame.
  task automatic word(input logic [6:0] idx, input logic [15:0] d);
    send_bits({1'b0, idx, d}, 24);
  endtask : word

  // Retune from stored settings; the pump is muted so no half-written divider is chased.
  task automatic retune(input sfrs_pkg::sfrs_cal_t c, input logic [15:0] dv, nm, dn, pg);
    word(sfrs_pkg::IDX_PUMP, 16'h0000);
    word(sfrs_pkg::IDX_CORE, {13'h0000, c.core});
    word(sfrs_pkg::IDX_BAND, {8'h00, c.band});
    word(sfrs_pkg::IDX_AMP, {7'h00, c.amp});
    word(sfrs_pkg::IDX_INT_DIV, dv);
    word(sfrs_pkg::IDX_NUMER, nm);
    word(sfrs_pkg::IDX_DENOM, dn);
    word(sfrs_pkg::IDX_PUMP, pg);
  endtask : retune
endmodule : sfrs_spi_ctrl

// *** dv/sfrs_top_tb.sv ***
`timescale 1ns/1ps
module sfrs_top_tb;
  localparam int CAL_N = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sclk, csb_n, sdi, locked, cal_busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] d, nm, dn;
  logic [15:0] divs [2];
  sfrs_pkg::sfrs_cal_t tbl [2];
  sfrs_pkg::sfrs_cal_t ec;
  int errors, comparisons, cycles, n;

  sfrs_top #(.CAL_CYCLES(CAL_N)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .locked(locked), .cal_busy(cal_busy)
  );
  sfrs_spi_ctrl i_ctrl (.sclk(sclk), .csb_n(csb_n), .sdi(sdi));

  // Clock and hang guard; the ceiling is several times the expected run.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end

  // ************************************************************
  // Expectations and bus tasks
  // ************************************************************
  // Calibration result the block derives from the divider at start.
  function automatic sfrs_pkg::sfrs_cal_t cal_of(input logic [15:0] v);
    sfrs_pkg::sfrs_cal_t c;
    c.core = v[8:6];
    c.band = ~v[7:0];
    c.amp = {v[3:0], 5'h10};
    return c;
  endfunction : cal_of

  function automatic logic [11:0] addr_of(input logic [6:0] i);
    return {3'h0, i, 2'b00};
  endfunction : addr_of

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; an idle edge follows so psel is never set twice in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends when pready rises; only the bench's hang guard bounds it.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee,
                        input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, e, rd);
    check("slave error", {31'h0, ee}, {31'h0, err});
  endtask : rd_chk

  task automatic link(input logic [6:0] i, input logic [15:0] v, input logic r);
    i_ctrl.send_bits({r, i, v}, 24);
    @(posedge pclk);
  endtask : link

  task automatic idle_wait(input int k);
    repeat (k) @(posedge pclk);
  endtask : idle_wait

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    // A deferred update lets every flop reset by presetn see the falling edge.
    presetn <= 1'b0;
    {errors, comparisons, cycles} = '0;
    void'($urandom(32'hBAA4BCAD));
    idle_wait(16);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, map edges and the read-only status word.
    rd_chk(sfrs_pkg::ADDR_CTRL, sfrs_pkg::CTRL_RESET, 1'b0, "ctrl");
    apb(1'b1, sfrs_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rd_chk(sfrs_pkg::ADDR_STATUS, 32'h0, 1'b0, "status");
    rd_chk(addr_of(7'd125), 32'h0, 1'b0, "last reg");
    rd_chk(sfrs_pkg::BANK_END, 32'h0, 1'b1, "unmapped");
    rd_chk(12'h006, 32'h0, 1'b1, "misaligned");
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 125 : $urandom_range(125, 45);
      d = 16'($urandom);
      apb(1'b1, addr_of(7'(n)), {16'hA5A5, d});
      rd_chk(addr_of(7'(n)), {16'h0, d}, 1'b0, "bank");
    end
    // Serial writes, then refused and truncated frames leave the value alone.
    d = 16'($urandom);
    link(7'd5, d, 1'b0);
    rd_chk(addr_of(7'd5), {16'h0, d}, 1'b0, "link word");
    link(7'd5, ~d, 1'b1);
    link(7'd126, ~d, 1'b0);
    apb(1'b1, sfrs_pkg::ADDR_CTRL, 32'h0);
    link(7'd5, ~d, 1'b0);
    apb(1'b1, sfrs_pkg::ADDR_CTRL, 32'h1);
    rd_chk(sfrs_pkg::ADDR_STATUS, 32'h4, 1'b0, "word count");
    i_ctrl.send_bits({1'b0, 7'd5, ~d}, 16);
    @(posedge pclk);
    rd_chk(addr_of(7'd5), {16'h0, d}, 1'b0, "kept word");
    // Auto calibration builds the table from readback, start by link then by APB.
    for (int f = 0; f < 2; f++) begin
      divs[f] = (f == 0) ? 16'hFFFF : 16'($urandom);
      link(sfrs_pkg::IDX_INT_DIV, divs[f], 1'b0);
      link(sfrs_pkg::IDX_NUMER, 16'($urandom), 1'b0);
      if (f == 0) begin
        link(sfrs_pkg::IDX_CAL_CTRL, 16'h0008, 1'b0);
      end else begin
        apb(1'b1, addr_of(sfrs_pkg::IDX_CAL_CTRL), 32'h8);
        @(posedge pclk);
        check("cal busy", 32'h1, {31'h0, cal_busy});
      end
      while (cal_busy !== 1'b0) @(posedge pclk);
      ec = cal_of(divs[f]);
      apb(1'b0, addr_of(sfrs_pkg::IDX_CORE), 32'h0);
      tbl[f].core = rd[2:0];
      check("core", {29'h0, ec.core}, rd);
      apb(1'b0, addr_of(sfrs_pkg::IDX_BAND), 32'h0);
      tbl[f].band = rd[7:0];
      check("band", {24'h0, ec.band}, rd);
      apb(1'b0, addr_of(sfrs_pkg::IDX_AMP), 32'h0);
      tbl[f].amp = rd[8:0];
      check("amp", {23'h0, ec.amp}, rd);
    end
    link(sfrs_pkg::IDX_PUMP, 16'h0070, 1'b0);
    idle_wait(3);
    check("lock cal", 32'h1, {31'h0, locked});
    link(sfrs_pkg::IDX_INT_DIV, divs[0], 1'b0);
    idle_wait(3);
    check("lock no force", 32'h0, {31'h0, locked});
    // Assisted retunes; each pass is one frequency-change request.
    link(sfrs_pkg::IDX_FORCE, 16'h1C00, 1'b0);
    nm = 16'($urandom);
    dn = 16'($urandom);
    for (int k = 0; k < 4; k++) begin
      n = k % 2;
      i_ctrl.retune(tbl[n], divs[n], nm, dn, 16'h0050);
      idle_wait(3);
      check("lock assisted", 32'h1, {31'h0, locked});
      rd_chk(addr_of(sfrs_pkg::IDX_BAND), {24'h0, tbl[n].band}, 1'b0, "band kept");
      rd_chk(addr_of(sfrs_pkg::IDX_INT_DIV), {16'h0, divs[n]}, 1'b0, "divider");
    end
    link(sfrs_pkg::IDX_PUMP, 16'h0000, 1'b0);
    idle_wait(3);
    check("lock pump off", 32'h0, {31'h0, locked});
    print_verdict();
  end
endmodule : sfrs_top_tb

// *** hw/sfrs_cal.sv ***
`timescale 1ns/1ps
module sfrs_cal #(
  parameter int CYCLES = sfrs_pkg::CAL_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic start,
  input wire logic [15:0] divider,
  // Result
  output logic busy,
  output logic done,
  output sfrs_pkg::sfrs_cal_t result
);

  // ************************************************************
  // Calibration timer
  // ************************************************************
  logic [15:0] remain;
  wire launch = start && !busy;
  wire finish = busy && (remain == 16'h0001);

  // A start during a run is ignored; the run in flight owns the result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      remain <= 16'h0000;
    end else begin
      busy <= launch || (busy && !finish);
      done <= finish;
      remain <= launch ? 16'(CYCLES) : (busy ? remain - 16'h0001 : remain);
    end
  end

  // The settings are derived from the divider as it stood at the start.
  // The mapping is a stand-in for the analog search, cut from bit fields of the divider with the band inverted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (launch) begin
      result.core <= divider[8:6];
      result.band <= ~divider[7:0];
      result.amp <= {divider[3:0], 5'h10};
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_cal_run_bound: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> remain <= 16'(CYCLES))
    else $error("Calibration timer exceeded its length.");

  a_cal_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    launch |=> busy && !done)
    else $error("Calibration did not start after the request.");

endmodule : sfrs_cal

// *** hw/sfrs_link.sv ***
`timescale 1ns/1ps
module sfrs_link (
  // Serial link, all on the link clock
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdi,
  // Reset of the whole block
  input wire logic presetn,
  // Completed word and its event toggle
  output sfrs_pkg::sfrs_word_t word,
  output logic word_tog
);

  // ************************************************************
  // Shift register and bit counter
  // ************************************************************
  logic [4:0] bit_cnt;
  logic [22:0] shift;
  wire last_bit = (bit_cnt == 5'(sfrs_pkg::LINK_BITS - 1));

  // The counter is cleared by the chip select itself, because the link clock
  // stops between frames and no edge would arrive to clear it.
  always_ff @(posedge sclk or posedge csb_n) begin
    if (csb_n) begin
      bit_cnt <= 5'h00;
    end else begin
      bit_cnt <= last_bit ? 5'h00 : bit_cnt + 5'h01;
    end
  end

  // Bits arrive most significant first.
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      shift <= 23'h000000;
    end else begin
      shift <= {shift[21:0], sdi};
    end
  end

  // The word stays put until the next full word, so the other domain may read it
  // after the toggle has crossed. Short frames never reach it.
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      word <= '0;
      word_tog <= 1'b0;
    end else if (last_bit) begin
      word <= {shift, sdi};
      word_tog <= ~word_tog;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_link_word_end: assert property (@(posedge sclk) disable iff (!presetn)
    (last_bit && !csb_n) |=> word_tog != $past(word_tog))
    else $error("Word toggle did not follow the 24th bit.");

endmodule : sfrs_link

// *** hw/sfrs_pkg.sv ***
package sfrs_pkg;

  // ************************************************************
  // Register bank geometry and indices
  // ************************************************************
  localparam int NUM_REGS = 126;
  localparam int IDX_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] IDX_CAL_CTRL = 7'h00;
  localparam logic [6:0] IDX_FORCE = 7'h08;
  localparam logic [6:0] IDX_PUMP = 7'h0E;
  localparam logic [6:0] IDX_AMP = 7'h10;
  localparam logic [6:0] IDX_BAND = 7'h13;
  localparam logic [6:0] IDX_CORE = 7'h14;
  localparam logic [6:0] IDX_INT_DIV = 7'h24;
  localparam logic [6:0] IDX_DENOM = 7'h27;
  localparam logic [6:0] IDX_NUMER = 7'h2B;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CAL_START_BIT = 3;
  localparam int PUMP_LSB = 4;
  localparam int PUMP_W = 3;
  localparam int CORE_FORCE_BIT = 10;
  localparam int BAND_FORCE_BIT = 11;
  localparam int AMP_FORCE_BIT = 12;
  localparam int CORE_LSB = 0;
  localparam int CORE_W = 3;
  localparam int BAND_LSB = 0;
  localparam int BAND_W = 8;
  localparam int AMP_LSB = 0;
  localparam int AMP_W = 9;

  // ************************************************************
  // Bus map beyond the bank and timing
  // ************************************************************
  localparam logic [11:0] ADDR_STATUS = 12'h200;
  localparam logic [11:0] ADDR_CTRL = 12'h204;
  localparam logic [11:0] BANK_END = 12'h1F8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int LINK_BITS = 24;
  localparam int CAL_CYCLES = 64;

  // One serial register write as it arrives on the link.
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [15:0] data;
  } sfrs_word_t;

  // Oscillator settings produced by one calibration run.
  typedef struct packed {
    logic [2:0] core;
    logic [7:0] band;
    logic [8:0] amp;
  } sfrs_cal_t;

endpackage : sfrs_pkg

// *** hw/sfrs_top.sv ***
// What this block does
// - Bank of 126 registers holds synthesizer state.
// - Setting bit 3 of register 0 starts calibration.
// - Calibration stores core, band, amplitude settings.
// - Link clock accepted up to 75 MHz.
// - Override enables make written settings take effect.
`timescale 1ns/1ps
module sfrs_top #(
  parameter int CAL_CYCLES = sfrs_pkg::CAL_CYCLES
) (
  // APB register port
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Serial link, up to 75 MHz on its own clock
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdi,
  // Synthesizer state
  output logic locked,
  output logic cal_busy
);

  // ************************************************************
  // Link domain and its crossing
  // ************************************************************
  sfrs_pkg::sfrs_word_t link_word;
  sfrs_pkg::sfrs_word_t held_word;
  logic link_tog;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic spi_pend;

  // The link logic samples on the link clock, which is why it tolerates 75 MHz.
  sfrs_link u_link (
    .sclk(sclk),
    .csb_n(csb_n),
    .sdi(sdi),
    .presetn(presetn),
    .word(link_word),
    .word_tog(link_tog)
  );

  // Two flip-flops for the toggle, a third only for the edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  wire word_arrived = tog_s2 ^ tog_s3;

  // ************************************************************
  // APB slave
  // ************************************************************
  logic [31:0] ctrl;
  logic [7:0] word_count;
  logic cal_valid;
  wire access = psel && penable;
  wire commit = access && pready;
  wire [6:0] apb_idx = paddr[8:2];
  wire bank_hit = (paddr < sfrs_pkg::BANK_END);
  wire status_hit = (paddr == sfrs_pkg::ADDR_STATUS);
  wire ctrl_hit = (paddr == sfrs_pkg::ADDR_CTRL);
  wire addr_ok = (bank_hit || status_hit || ctrl_hit) && (paddr[1:0] == 2'h0);
  wire apb_wr = commit && pwrite && addr_ok && bank_hit;
  wire ctrl_wr = commit && pwrite && addr_ok && ctrl_hit;

  // A serial word waits one cycle when any APB transfer commits, so each cycle has
  // at most one bus writer and neither one is lost.
  wire spi_apply = spi_pend && !commit;
  wire spi_wr = spi_apply && ctrl[0] && !held_word.rd
    && (held_word.addr < 7'(sfrs_pkg::NUM_REGS));

  // Pending flag and held copy of the word; arrival wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_pend <= 1'b0;
      held_word <= '0;
    end else begin
      spi_pend <= word_arrived || (spi_pend && !spi_apply);
      if (word_arrived) begin
        held_word <= link_word;
      end
    end
  end

  // ************************************************************
  // Register bank
  // ************************************************************
  logic [15:0] bank [sfrs_pkg::NUM_REGS];
  sfrs_pkg::sfrs_cal_t cal_res;
  logic cal_done;
  wire [15:0] force_reg = bank[sfrs_pkg::IDX_FORCE];
  wire core_force = force_reg[sfrs_pkg::CORE_FORCE_BIT];
  wire band_force = force_reg[sfrs_pkg::BAND_FORCE_BIT];
  wire amp_force = force_reg[sfrs_pkg::AMP_FORCE_BIT];
  wire all_forced = core_force && band_force && amp_force;
  wire [2:0] pump_gain = bank[sfrs_pkg::IDX_PUMP][sfrs_pkg::PUMP_LSB +: sfrs_pkg::PUMP_W];

  // Each entry takes an APB write, then a serial write, then a calibration
  // result; a later source in that list wins when two aim at one entry.
  for (genvar i = 0; i < sfrs_pkg::NUM_REGS; i++) begin : g_bank
    logic [15:0] next_val;
    always_comb begin
      next_val = bank[i];
      if (apb_wr && apb_idx == 7'(i)) begin
        next_val = pwdata[15:0];
      end
      if (spi_wr && held_word.addr == 7'(i)) begin
        next_val = held_word.data;
      end
      if (cal_done && 7'(i) == sfrs_pkg::IDX_CORE && !core_force) begin
        next_val[sfrs_pkg::CORE_LSB +: sfrs_pkg::CORE_W] = cal_res.core;
      end
      if (cal_done && 7'(i) == sfrs_pkg::IDX_BAND && !band_force) begin
        next_val[sfrs_pkg::BAND_LSB +: sfrs_pkg::BAND_W] = cal_res.band;
      end
      if (cal_done && 7'(i) == sfrs_pkg::IDX_AMP && !amp_force) begin
        next_val[sfrs_pkg::AMP_LSB +: sfrs_pkg::AMP_W] = cal_res.amp;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bank[i] <= sfrs_pkg::REG_RESET;
      end else begin
        bank[i] <= next_val;
      end
    end
  end

  // ************************************************************
  // Calibration control
  // ************************************************************
  wire apb_cal = apb_wr && apb_idx == sfrs_pkg::IDX_CAL_CTRL && pwdata[sfrs_pkg::CAL_START_BIT];
  wire spi_cal = spi_wr && held_word.addr == sfrs_pkg::IDX_CAL_CTRL
    && held_word.data[sfrs_pkg::CAL_START_BIT];
  wire cal_start = apb_cal || spi_cal;

  // The divider register is read as it stands; with one writer per cycle a start never lands with it.
  wire [15:0] cal_div = bank[sfrs_pkg::IDX_INT_DIV];

  sfrs_cal #(
    .CYCLES(CAL_CYCLES)
  ) u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .start(cal_start),
    .divider(cal_div),
    .busy(cal_busy),
    .done(cal_done),
    .result(cal_res)
  );

  // ************************************************************
  // Lock model
  // ************************************************************
  wire spi_div = spi_wr && (held_word.addr == sfrs_pkg::IDX_INT_DIV
    || held_word.addr == sfrs_pkg::IDX_NUMER || held_word.addr == sfrs_pkg::IDX_DENOM);
  wire apb_div = apb_wr && (apb_idx == sfrs_pkg::IDX_INT_DIV
    || apb_idx == sfrs_pkg::IDX_NUMER || apb_idx == sfrs_pkg::IDX_DENOM);
  wire div_changed = spi_div || apb_div;

  // A new divider invalidates the old settings until calibration or full
  // override supplies them; a finishing calibration wins over the clear.
  wire next_cal_valid = cal_done || (cal_valid && !div_changed);

  // Lock needs valid settings and a running pump, so a zero gain during the
  // rewrite keeps the loop from chasing intermediate frequencies.
  wire next_locked = (cal_valid || all_forced) && !cal_busy
    && (pump_gain != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_valid <= 1'b0;
      locked <= 1'b0;
    end else begin
      cal_valid <= next_cal_valid;
      locked <= next_locked;
    end
  end

  // ************************************************************
  // Control, status and APB answer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= sfrs_pkg::CTRL_RESET;
      word_count <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl <= {31'h0000_0000, pwdata[0]};
      end
      if (spi_apply) begin
        word_count <= word_count + 8'h01;
      end
    end
  end

  wire [31:0] status_val = {21'h000000, cal_valid, locked, cal_busy, word_count};
  wire [31:0] read_val = bank_hit ? {16'h0000, bank[apb_idx]}
    : (status_hit ? status_val : ctrl);

  // One wait state; the answer is held back while a serial word is pending.
  wire next_pready = access && !pready && !spi_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      if (next_pready) begin
        prdata <= (addr_ok && !pwrite) ? read_val : 32'h0000_0000;
        pslverr <= !addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_cal_store_core: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_done && !core_force) |=>
      bank[sfrs_pkg::IDX_CORE][2:0] == $past(cal_res.core))
    else $error("Calibrated core choice was not stored.");

  a_force_keeps_core: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_done && core_force && !spi_wr && !apb_wr) |=>
      $stable(bank[sfrs_pkg::IDX_CORE]))
    else $error("Forced core choice was overwritten by calibration.");

  a_lock_needs_gain: assert property (@(posedge pclk) disable iff (!presetn)
    locked |-> $past(pump_gain) != 3'h0)
    else $error("Lock reported with pump gain at zero.");

  a_div_drops_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (div_changed && !cal_done && !all_forced) ##1 !all_forced |=> !locked)
    else $error("Lock held after a divider change without new settings.");

  a_cal_reg_start: assert property (@(posedge pclk) disable iff (!presetn)
    (cal_start && !cal_busy) |=> cal_busy ##[1:1000] cal_done)
    else $error("Calibration request did not complete.");

  a_apb_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready stood longer than one cycle.");

  a_apb_err_map: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && pslverr) |-> !addr_ok)
    else $error("Error answer for a mapped address.");

  a_spi_range: assert property (@(posedge pclk) disable iff (!presetn)
    spi_wr |-> held_word.addr <= 7'h7D)
    else $error("Serial write outside the register bank.");

  a_apb_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && !cal_done) |=> bank[$past(apb_idx)] == $past(pwdata[15:0]))
    else $error("Bus write did not land in the register bank.");

  a_link_bank_write: assert property (@(posedge pclk) disable iff (!presetn)
    (spi_wr && !cal_done) |=> bank[$past(held_word.addr)] == $past(held_word.data))
    else $error("Serial write did not land in the register bank.");

  a_forced_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (all_forced && !cal_busy && pump_gain != 3'h0) |=> locked)
    else $error("Lock missing with all overrides set and pump running.");

  a_word_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    spi_apply |=> word_count == $past(word_count) + 8'h01)
    else $error("Serial word count did not advance.");

  c_cal_run: cover property (@(posedge pclk) disable iff (!presetn) cal_done);
  c_spi_word: cover property (@(posedge pclk) disable iff (!presetn) spi_wr);
  c_lock_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(locked));
  c_apb_stall: cover property (@(posedge pclk) disable iff (!presetn)
    access && !pready && spi_pend);

endmodule : sfrs_top
